// ===== src/pss_sequencer.sv
// Overview of operation
// - Latch power-ok failure; reboot on resume
// - Debounce front button over 16 ms
// - Standby good: sleep controls, bus reset active
// - Resume reset release: controls inactive 1-4 RTC
// - Bus reset held 500 us past clocks
// - Bus reset released 0.9-1.1 ms after power-ok
// - Hub handshake: first cycle, then second
// - Clock-stop released 1-4 PCI after bus reset
// - Straps valid from bus reset release until second cycle
// - Processor reset released by second cycle
// - Processor sleep within 8 PCI of grant
// - Suspend status, bus reset, suspend-RAM order
// - Soft-off 1-2 RTC after suspend-RAM
// - Soft-off exit: suspend-RAM 2-3 RTC later
// - Wake: suspend-RAM released 2-3 RTC later
// - Button press wakes from S1 to S5
// - Running press raises SCI if enabled, else SMI
// - Four-second hold forces soft-off
`timescale 1ns/10ps
`default_nettype none

module pss_sequencer #(
  parameter int DEBOUNCE_CYC  = pss_pkg::DEBOUNCE_CYC,
  parameter int OVERRIDE_CYC  = pss_pkg::OVERRIDE_CYC,
  parameter int CLK_VALID_CYC = pss_pkg::CLK_VALID_CYC,
  parameter int POK_CYC       = pss_pkg::POK_CYC,
  parameter int RTC_DIV       = pss_pkg::RTC_DIV,
  parameter int PCI_DIV       = pss_pkg::PCI_DIV
) (
  input  wire logic                i_clock,
  input  wire logic                i_resetn,
  input  wire logic                i_resume_well_reset_n,
  input  wire logic                i_main_power_ok,
  input  wire logic                i_clocks_valid,
  input  wire logic                i_front_button_n,
  input  wire logic                i_hub_cycle_two,
  input  wire logic                i_wake_event,
  input  wire logic                i_stop_grant,
  input  wire logic                i_sleep_req,
  input  wire logic [1:0]          i_sleep_type,
  input  wire logic [7:0]          i_cfg_addr,
  input  wire logic                i_cfg_write,
  input  wire logic [7:0]          i_cfg_wdata,
  output logic      [7:0]          o_cfg_rdata,
  output pss_pkg::pss_pins_t       o_ctrl,
  output logic                     o_hub_cycle_one,
  output logic                     o_sci,
  output logic                     o_smi
);

  initial begin
    if (RTC_DIV < 2 || RTC_DIV >= (1 << pss_pkg::DIV_W) || PCI_DIV < 2
        || PCI_DIV >= RTC_DIV || POK_CYC < 2 || CLK_VALID_CYC < 2
        || OVERRIDE_CYC < 2) begin
      $error("pss_sequencer: unsupported timing parameters");
    end
  end

  typedef enum logic [4:0] {
    ST_RSM,
    ST_RSM_EXIT,
    ST_CORE_WAIT,
    ST_BUS_ON,
    ST_HUB_WAIT,
    ST_RUN,
    ST_STOP,
    ST_PROCESSOR_SLEEP_N,
    ST_S1,
    ST_SUSST,
    ST_BUSRST,
    ST_S3ENT,
    ST_S3,
    ST_S5,
    ST_S5_EXIT,
    ST_WAKE
  } pss_state_t;

  localparam int NSYNC = 6;
  // Button pin idles high, the other pins idle low
  localparam logic [NSYNC-1:0] SYNC_IDLE = 6'h08;

  function automatic logic reached(input logic [pss_pkg::TICK_W-1:0] cnt,
                                   input int limit);
    reached = (cnt >= pss_pkg::TICK_W'(limit));
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end else begin
      sync1_r <= {i_wake_event, i_hub_cycle_two, i_front_button_n,
                  i_clocks_valid, i_main_power_ok, i_resume_well_reset_n};
      sync2_r <= sync1_r;
    end
  end

  logic rsm_ok;
  logic pok;
  logic clk_ok;
  logic button_raw_n;
  logic cyc2;
  logic wake_in;

  assign rsm_ok       = sync2_r[0];
  assign pok          = sync2_r[1];
  assign clk_ok       = sync2_r[2];
  assign button_raw_n = sync2_r[3];
  assign cyc2         = sync2_r[4];
  assign wake_in      = sync2_r[5];

  // ==========================================================================
  // RTC and PCI tick enables
  logic [pss_pkg::DIV_W-1:0] rtc_div_r;
  logic [pss_pkg::DIV_W-1:0] pci_div_r;
  logic                      rtc_tick;
  logic                      pci_tick;

  assign rtc_tick = (rtc_div_r == pss_pkg::DIV_W'(RTC_DIV - 1));
  assign pci_tick = (pci_div_r == pss_pkg::DIV_W'(PCI_DIV - 1));

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rtc_div_r <= '0;
      pci_div_r <= '0;
    end else if (!rsm_ok) begin
      rtc_div_r <= '0;
      pci_div_r <= '0;
    end else begin
      rtc_div_r <= rtc_tick ? '0 : rtc_div_r + 1'b1;
      pci_div_r <= pci_tick ? '0 : pci_div_r + 1'b1;
    end
  end

  // ==========================================================================
  // Front button: debounce, press edge, long-hold override
  logic                       button_n;
  logic                       button_d_r;
  logic                       press;
  logic [pss_pkg::TIMER_W-1:0] hold_cnt_r;
  logic                       override;

  pss_debounce #(
    .CYC (DEBOUNCE_CYC)
  ) u_debounce (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_clear  (!rsm_ok),
    .i_raw    (button_raw_n),
    .o_level  (button_n)
  );

  assign press    = button_d_r && !button_n;
  assign override = (hold_cnt_r == pss_pkg::TIMER_W'(OVERRIDE_CYC - 1));

  // Hold counter, one pulse per hold
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      button_d_r <= 1'b1;
      hold_cnt_r <= '0;
    end else begin
      button_d_r <= button_n;
      if (button_n || !rsm_ok) begin
        hold_cnt_r <= '0;
      end else if (hold_cnt_r != pss_pkg::TIMER_W'(OVERRIDE_CYC)) begin
        hold_cnt_r <= hold_cnt_r + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Power-ok and clocks-valid timers, cleared while their input is low
  logic [pss_pkg::TIMER_W-1:0] pok_cnt_r;
  logic [pss_pkg::TIMER_W-1:0] clk_cnt_r;
  logic                        pok_done;
  logic                        clk_done;

  assign pok_done = (pok_cnt_r >= pss_pkg::TIMER_W'(POK_CYC - 1));
  assign clk_done = (clk_cnt_r >= pss_pkg::TIMER_W'(CLK_VALID_CYC - 1));

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pok_cnt_r <= '0;
      clk_cnt_r <= '0;
    end else begin
      pok_cnt_r <= !pok ? '0 : (pok_done ? pok_cnt_r : pok_cnt_r + 1'b1);
      clk_cnt_r <= !clk_ok ? '0 : (clk_done ? clk_cnt_r : clk_cnt_r + 1'b1);
    end
  end

  // ==========================================================================
  // Sequencer state machine
  pss_state_t                 state_r;
  pss_state_t                 state_nxt;
  logic [pss_pkg::TICK_W-1:0] tick_cnt_r;
  pss_pkg::pss_sleep_t        target_r;
  logic                       core_on;
  logic                       pok_fail;
  logic                       sci_en;
  logic                       flag_set;

  assign core_on  = (state_r == ST_BUS_ON) || (state_r == ST_HUB_WAIT)
                 || (state_r == ST_RUN) || (state_r == ST_STOP)
                 || (state_r == ST_PROCESSOR_SLEEP_N) || (state_r == ST_S1);
  assign pok_fail = core_on && !pok;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RSM: begin
        state_nxt = ST_RSM_EXIT;
      end
      ST_RSM_EXIT: begin
        if (reached(tick_cnt_r, pss_pkg::RTC_RSM_TICKS)) begin
          state_nxt = ST_CORE_WAIT;
        end
      end
      ST_CORE_WAIT: begin
        if (pok_done && clk_done) begin
          state_nxt = ST_BUS_ON;
        end
      end
      ST_BUS_ON: begin
        if (reached(tick_cnt_r, pss_pkg::PCI_STOP_TICKS)) begin
          state_nxt = ST_HUB_WAIT;
        end
      end
      ST_HUB_WAIT: begin
        if (cyc2) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_sleep_req) begin
          state_nxt = ST_STOP;
        end
      end
      ST_STOP: begin
        if (i_stop_grant) begin
          state_nxt = ST_PROCESSOR_SLEEP_N;
        end
      end
      ST_PROCESSOR_SLEEP_N: begin
        if (reached(tick_cnt_r, pss_pkg::PCI_SLP_TICKS)) begin
          state_nxt = (target_r == pss_pkg::SLEEP_S1) ? ST_S1 : ST_SUSST;
        end
      end
      ST_S1: begin
        if (press || wake_in) begin
          state_nxt = ST_RUN;
        end
      end
      ST_SUSST: begin
        if (reached(tick_cnt_r, pss_pkg::RTC_BUSRST_TICKS)) begin
          state_nxt = ST_BUSRST;
        end
      end
      ST_BUSRST: begin
        if (reached(tick_cnt_r, pss_pkg::RTC_S3_TICKS)) begin
          state_nxt = (target_r == pss_pkg::SLEEP_S5) ? ST_S3ENT : ST_S3;
        end
      end
      ST_S3ENT: begin
        if (reached(tick_cnt_r, pss_pkg::RTC_S5_TICKS)) begin
          state_nxt = ST_S5;
        end
      end
      ST_S3: begin
        if (press || wake_in) begin
          state_nxt = ST_WAKE;
        end
      end
      // Wake from soft-off by button only
      ST_S5: begin
        if (press) begin
          state_nxt = ST_S5_EXIT;
        end
      end
      ST_S5_EXIT: begin
        if (reached(tick_cnt_r, pss_pkg::RTC_S5EXIT_TICKS)) begin
          state_nxt = ST_CORE_WAIT;
        end
      end
      ST_WAKE: begin
        if (reached(tick_cnt_r, pss_pkg::RTC_WAKE_TICKS)) begin
          state_nxt = ST_CORE_WAIT;
        end
      end
      default: begin
        state_nxt = ST_RSM;
      end
    endcase
    // Main power lost while the core should be up: fall back to waiting
    if (pok_fail) begin
      state_nxt = ST_CORE_WAIT;
    end
    // Override skips software and the stop-grant wait
    if (override && (core_on || state_r == ST_CORE_WAIT)) begin
      state_nxt = ST_SUSST;
    end
    // Resume reset forces every control active except processor sleep and strap-valid
    if (!rsm_ok) begin
      state_nxt = ST_RSM;
    end
  end

  // Tick counter restarts on each state change
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r    <= ST_RSM;
      tick_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || !rsm_ok) begin
        tick_cnt_r <= '0;
      end else if (state_r == ST_BUS_ON || state_r == ST_PROCESSOR_SLEEP_N) begin
        if (pci_tick && !reached(tick_cnt_r, pss_pkg::PCI_STOP_TICKS + 1)) begin
          tick_cnt_r <= tick_cnt_r + 1'b1;
        end
      end else if (rtc_tick && !reached(tick_cnt_r, pss_pkg::RTC_WAKE_TICKS + 1)) begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // Sleep target captured with the request; override always means soft-off
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      target_r <= pss_pkg::SLEEP_S3;
    end else if (override && (core_on || state_r == ST_CORE_WAIT)) begin
      target_r <= pss_pkg::SLEEP_S5;
    end else if (state_r == ST_RUN && i_sleep_req) begin
      if (i_sleep_type == 2'(pss_pkg::SLEEP_S1)) begin
        target_r <= pss_pkg::SLEEP_S1;
      end else if (i_sleep_type == 2'(pss_pkg::SLEEP_S3)) begin
        target_r <= pss_pkg::SLEEP_S3;
      end else begin
        target_r <= pss_pkg::SLEEP_S5;
      end
    end
  end

  // ==========================================================================
  // Pin outputs, registered from the next state
  pss_pkg::pss_pins_t pins_nxt;

  always_comb begin
    pins_nxt = PINS_ACTIVE_NONE();
    case (state_nxt)
      ST_RSM, ST_RSM_EXIT: begin
        pins_nxt = pss_pkg::PINS_RESET;
        pins_nxt.processor_sleep_n = 1'b1;
      end
      ST_CORE_WAIT, ST_S5_EXIT, ST_WAKE: begin
        pins_nxt.bus_reset_n            = 1'b0;
        pins_nxt.processor_clock_stop_n = 1'b0;
        pins_nxt.processor_reset_n      = 1'b0;
      end
      // Straps valid from bus reset release
      ST_BUS_ON: begin
        pins_nxt.processor_clock_stop_n = 1'b0;
        pins_nxt.processor_reset_n      = 1'b0;
        pins_nxt.strap_valid            = 1'b1;
      end
      ST_HUB_WAIT: begin
        pins_nxt.processor_reset_n = 1'b0;
        pins_nxt.strap_valid       = 1'b1;
      end
      ST_STOP: begin
        pins_nxt.processor_clock_stop_n = 1'b0;
      end
      ST_PROCESSOR_SLEEP_N, ST_S1: begin
        pins_nxt.processor_clock_stop_n = 1'b0;
        pins_nxt.processor_sleep_n      = 1'b0;
      end
      ST_SUSST: begin
        pins_nxt = SLEEP_PINS(1'b0, 1'b0, 1'b0);
      end
      ST_BUSRST: begin
        pins_nxt = SLEEP_PINS(1'b1, 1'b0, 1'b0);
      end
      ST_S3ENT, ST_S3: begin
        pins_nxt = SLEEP_PINS(1'b1, 1'b1, 1'b0);
      end
      ST_S5: begin
        pins_nxt = SLEEP_PINS(1'b1, 1'b1, 1'b1);
      end
      default: begin
        pins_nxt = PINS_ACTIVE_NONE();
      end
    endcase
    // Keep suspend-RAM asserted through the soft-off exit delay
    if (state_nxt == ST_S5_EXIT && state_r != ST_CORE_WAIT) begin
      pins_nxt.suspend_ram_ctrl_n = 1'b0;
    end
    if (state_nxt == ST_WAKE) begin
      pins_nxt.suspend_ram_ctrl_n = 1'b0;
      pins_nxt.suspend_status_n   = 1'b0;
    end
  end

  function automatic pss_pkg::pss_pins_t PINS_ACTIVE_NONE();
    PINS_ACTIVE_NONE = '1;
    PINS_ACTIVE_NONE.strap_valid = 1'b0;
  endfunction

  function automatic pss_pkg::pss_pins_t SLEEP_PINS(input logic bus_rst,
                                                    input logic s3,
                                                    input logic s5);
    SLEEP_PINS = '0;
    SLEEP_PINS.suspend_ram_ctrl_n = ~s3;
    SLEEP_PINS.soft_off_ctrl_n    = ~s5;
    SLEEP_PINS.bus_reset_n        = ~bus_rst;
  endfunction

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ctrl <= pss_pkg::PINS_RESET;
    end else begin
      o_ctrl <= pins_nxt;
    end
  end

  // First hub cycle once clock-stop releases
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hub_cycle_one <= 1'b0;
    end else begin
      o_hub_cycle_one <= (state_r == ST_BUS_ON) && (state_nxt == ST_HUB_WAIT);
    end
  end

  // Running press raises SCI or SMI
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sci <= 1'b0;
      o_smi <= 1'b0;
    end else begin
      o_sci <= press && state_r == ST_RUN && sci_en;
      o_smi <= press && state_r == ST_RUN && !sci_en;
    end
  end

  // ==========================================================================
  // Configuration register; hardware set wins over a write-one clear
  logic [7:0] cfg_r;
  logic [7:0] w1c;

  assign w1c      = (i_cfg_write && i_cfg_addr == pss_pkg::CFG_ADDR) ? i_cfg_wdata : '0;
  assign sci_en   = cfg_r[pss_pkg::BIT_SCI_EN];
  assign flag_set = pok_fail;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_r <= pss_pkg::CFG_RESET;
    end else begin
      cfg_r[pss_pkg::BIT_POK_FLR] <= flag_set
                                  || (cfg_r[pss_pkg::BIT_POK_FLR] && !w1c[pss_pkg::BIT_POK_FLR]);
      cfg_r[pss_pkg::BIT_BTN_STS] <= (press && state_r == ST_RUN)
                                  || (cfg_r[pss_pkg::BIT_BTN_STS] && !w1c[pss_pkg::BIT_BTN_STS]);
      cfg_r[pss_pkg::BIT_OVR_STS] <= override
                                  || (cfg_r[pss_pkg::BIT_OVR_STS] && !w1c[pss_pkg::BIT_OVR_STS]);
      if (i_cfg_write && i_cfg_addr == pss_pkg::CFG_ADDR) begin
        cfg_r[pss_pkg::BIT_SCI_EN] <= i_cfg_wdata[pss_pkg::BIT_SCI_EN];
      end
      // Resume from S3 with flag set becomes a reboot
      if (state_r == ST_S3 && state_nxt == ST_WAKE && cfg_r[pss_pkg::BIT_POK_FLR]) begin
        cfg_r[pss_pkg::BIT_REBOOT] <= 1'b1;
      end else if (!cfg_r[pss_pkg::BIT_POK_FLR]) begin
        cfg_r[pss_pkg::BIT_REBOOT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cfg_rdata <= '0;
    end else begin
      o_cfg_rdata <= (i_cfg_addr == pss_pkg::CFG_ADDR) ? (cfg_r & 8'h1f) : '0;
    end
  end

endmodule

`default_nettype wire

// ===== src/pss_pkg.sv
package pss_pkg;

  // ==========================================================================
  // Clock rates and derived tick dividers
  localparam int CLK_HZ  = 100_000_000;
  localparam int RTC_HZ  = 32_768;
  localparam int PCI_HZ  = 33_333_333;
  localparam int RTC_DIV = CLK_HZ / RTC_HZ;
  localparam int PCI_DIV = CLK_HZ / PCI_HZ;
  localparam int DIV_W   = 12;

  // ==========================================================================
  // Times in their own units and cycle counts derived from them
  localparam int DEBOUNCE_MS    = 16;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * (CLK_HZ / 1_000);
  localparam int OVERRIDE_S     = 4;
  localparam int OVERRIDE_CYC   = OVERRIDE_S * CLK_HZ;
  localparam int CLK_VALID_US   = 500;
  localparam int CLK_VALID_CYC  = CLK_VALID_US * (CLK_HZ / 1_000_000);
  // Bus reset release aims at the middle of the 0.9 to 1.1 ms window
  localparam int POK_RELEASE_US = 1_000;
  localparam int POK_CYC        = POK_RELEASE_US * (CLK_HZ / 1_000_000);
  localparam int TIMER_W        = 32;

  // ==========================================================================
  // Tick counts; n ticks after an arbitrary event land within (n-1, n] periods
  localparam int TICK_W           = 4;
  localparam int RTC_RSM_TICKS    = 2;
  localparam int RTC_SUS_TICKS    = 1;
  localparam int RTC_BUSRST_TICKS = 3;
  localparam int RTC_S3_TICKS     = 2;
  localparam int RTC_S5_TICKS     = 2;
  localparam int RTC_WAKE_TICKS   = 3;
  localparam int RTC_S5EXIT_TICKS = 3;
  localparam int PCI_STOP_TICKS   = 2;
  localparam int PCI_SLP_TICKS    = 2;

  // ==========================================================================
  // Configuration register
  localparam logic [7:0] CFG_ADDR    = 8'ha2;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam int         BIT_POK_FLR = 0;
  localparam int         BIT_BTN_STS = 1;
  localparam int         BIT_OVR_STS = 2;
  localparam int         BIT_SCI_EN  = 3;
  localparam int         BIT_REBOOT  = 4;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    SLEEP_S1,
    SLEEP_S3,
    SLEEP_S5
  } pss_sleep_t;

  typedef struct packed {
    logic suspend_ram_ctrl_n;
    logic soft_off_ctrl_n;
    logic suspend_status_n;
    logic bus_reset_n;
    logic processor_sleep_n;
    logic processor_clock_stop_n;
    logic processor_reset_n;
    logic strap_valid;
  } pss_pins_t;

  localparam pss_pins_t PINS_RESET = '0;

endpackage

// ===== src/pss_debounce.sv
`timescale 1ns/10ps
`default_nettype none

module pss_debounce #(
  parameter int CYC = 1_600_000
) (
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_clear,
  input  wire logic i_raw,
  output logic      o_level
);

  localparam int W = $clog2(CYC + 1);

  logic [W-1:0] cnt_r;
  logic         level_r;

  initial begin
    if (CYC < 2) begin
      $error("pss_debounce: CYC must be at least 2");
    end
  end

  // ==========================================================================
  // Level moves after the input has differed for CYC cycles, or to high at once on clear
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r   <= '0;
      level_r <= 1'b1;
    end else if (i_clear) begin
      cnt_r   <= '0;
      level_r <= 1'b1;
    end else if (i_raw == level_r) begin
      cnt_r <= '0;
    end else if (cnt_r == W'(CYC - 1)) begin
      cnt_r   <= '0;
      level_r <= i_raw;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign o_level = level_r;

endmodule

`default_nettype wire

// ===== bench/pss_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pss_chk #(
  parameter int RTC_DIV = 12,
  parameter int PCI_DIV = 3
) (
  input wire logic               i_clock,
  input wire logic               i_resetn,
  input wire logic               i_resume_well_reset_n,
  input wire logic               i_hub_cycle_two,
  input wire logic               i_wake_event,
  input wire logic               i_stop_grant,
  input wire pss_pkg::pss_pins_t o_ctrl,
  input wire logic               o_sci
);
  localparam int P1 = PCI_DIV;
  localparam int P4 = 4 * PCI_DIV;
  localparam int P8 = 8 * PCI_DIV;
  localparam int R1 = RTC_DIV;
  localparam int R2 = 2 * RTC_DIV;
  localparam int R2X = 2 * RTC_DIV + 1;
  // One more for the registered output seen through a past look
  localparam int R2Y = 2 * RTC_DIV + 2;
  // Sync stages in front of the tick counters add a few cycles
  localparam int R3X = 3 * RTC_DIV + 3;
  localparam int R3W = 3 * RTC_DIV + 4;
  localparam int R4X = 4 * RTC_DIV + 4;
  // ==========================================================================
  // Sequencing properties
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  a_rsm_all_act: assert property (!i_resume_well_reset_n [*5] |-> o_ctrl[7:4] == 4'h0)
    else $error("controls not active");
  a_rsm_release: assert property ($rose(i_resume_well_reset_n) |->
    ##[R1:R4X] ($rose(o_ctrl.suspend_ram_ctrl_n) && o_ctrl[6:5] == 2'h3)) else $error("late");
  a_clkstop_rel: assert property ($rose(o_ctrl.bus_reset_n) |-> o_ctrl.strap_valid
    ##[P1:P4] $rose(o_ctrl.processor_clock_stop_n)) else $error("clock stop");
  a_cpu_rst_rel: assert property ($rose(i_hub_cycle_two) |->
    ##[1:11] o_ctrl.processor_reset_n) else $error("cpu reset");
  a_strap_drop: assert property ($rose(i_hub_cycle_two) |->
    ##[1:18] !o_ctrl.strap_valid) else $error("straps");
  a_grant_sleep: assert property (i_stop_grant && !o_ctrl.processor_clock_stop_n |->
    ##[1:P8] !o_ctrl.processor_sleep_n) else $error("sleep");
  a_status_bus: assert property ($fell(o_ctrl.suspend_status_n) |->
    ##[R2:R3X] $fell(o_ctrl.bus_reset_n)) else $error("bus reset");
  a_bus_ram: assert property ($fell(o_ctrl.bus_reset_n) && !o_ctrl.processor_sleep_n |->
    ##[R1:R2X] $fell(o_ctrl.suspend_ram_ctrl_n)) else $error("ram ctrl");
  a_ram_soft: assert property ($fell(o_ctrl.soft_off_ctrl_n) && !o_ctrl.processor_sleep_n
    |-> !$past(o_ctrl.suspend_ram_ctrl_n, R1) && $past(o_ctrl.suspend_ram_ctrl_n, R2Y))
    else $error("off");
  a_soft_exit: assert property ($rose(o_ctrl.soft_off_ctrl_n)
    && !o_ctrl.suspend_ram_ctrl_n |-> ##[R2:R3X] $rose(o_ctrl.suspend_ram_ctrl_n))
    else $error("off exit");
  a_wake_ram: assert property ($rose(i_wake_event) && !o_ctrl.suspend_ram_ctrl_n |->
    ##[R2:R3W] $rose(o_ctrl.suspend_ram_ctrl_n)) else $error("wake");
  c_soft_off: cover property ($fell(o_ctrl.soft_off_ctrl_n));
  c_sci: cover property (o_sci);
  c_cpu_run: cover property ($rose(o_ctrl.processor_reset_n));
endmodule
bind pss_sequencer pss_chk #(.RTC_DIV(RTC_DIV), .PCI_DIV(PCI_DIV)) chk_u (.*);
`default_nettype wire

// ===== bench/pss_board.sv
`timescale 1ns/10ps
`default_nettype none
module pss_board (
  input  wire logic i_clock,
  input  wire logic i_ram_n,
  input  wire logic i_cyc_one,
  input  wire logic i_glitch,
  output logic      o_rsm_n,
  output logic      o_pok,
  output logic      o_clk_ok,
  output logic      o_cyc_two
);
  int age = 0;
  int core = 0;
  int hub = 0;
  logic supply_on_request;
  // ==========================================================================
  // Board power and hub behaviour
  // Supply request inverted
  assign supply_on_request = !i_ram_n;
  initial {o_rsm_n, o_pok, o_clk_ok, o_cyc_two} = 4'h0;
  always @(posedge i_clock) begin
    #1;
    age++;
    o_rsm_n = age > 40;
    core = supply_on_request ? 0 : core + 1;
    o_clk_ok = core > 4;
    o_pok = core > 10 && !i_glitch;
    hub = i_cyc_one ? 4 : (hub > 0 ? hub - 1 : 0);
    o_cyc_two = hub > 0;
  end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       btn_n = 1'b1;
  logic       wake = 1'b0;
  logic       grant = 1'b0;
  logic       req = 1'b0;
  logic       glitch = 1'b0;
  logic       wr = 1'b0;
  logic [1:0] stype = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, rd, ctrl, evts;
  logic       rsm_n, pok, clk_ok, cyc2, cyc1, sci, smi;
  int         errors = 0;
  int         n_checks = 0;
  int         sci_cnt = 0;
  int         smi_cnt = 0;
  int         n;
  assign evts = {sci_cnt[3:0], smi_cnt[3:0]};
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (sci === 1'b1) sci_cnt++;
    if (smi === 1'b1) smi_cnt++;
  end
  // ==========================================================================
  // Design and board
  pss_sequencer #(.DEBOUNCE_CYC(16), .OVERRIDE_CYC(200), .CLK_VALID_CYC(20),
    .POK_CYC(40), .RTC_DIV(12)) dut_u (
    .i_clock(clk), .i_resetn(rst_n), .i_resume_well_reset_n(rsm_n),
    .i_main_power_ok(pok), .i_clocks_valid(clk_ok), .i_front_button_n(btn_n),
    .i_hub_cycle_two(cyc2), .i_wake_event(wake), .i_stop_grant(grant),
    .i_sleep_req(req), .i_sleep_type(stype), .i_cfg_addr(addr), .i_cfg_write(wr),
    .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_ctrl(ctrl), .o_hub_cycle_one(cyc1),
    .o_sci(sci), .o_smi(smi));
  pss_board board_u (.i_clock(clk), .i_ram_n(ctrl[7]), .i_cyc_one(cyc1), .i_glitch(glitch),
    .o_rsm_n(rsm_n), .o_pok(pok), .o_clk_ok(clk_ok), .o_cyc_two(cyc2));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_ctrl(input logic [7:0] m, input logic [7:0] v);
    for (n = 0; n < 3000 && (ctrl & m) !== v; n++) tick(1);
    chk8(ctrl & m, v);
  endtask
  // Read data trails the address by one cycle, so sample after the second edge
  task automatic cfg(input logic [7:0] a, input logic w, input logic [7:0] d);
    addr = a;
    wr = w;
    wdata = d;
    tick(1);
    wr = 1'b0;
    tick(1);
    rd = rdata;
  endtask
  task automatic press(input int k);
    btn_n = 1'b0;
    tick(k);
    btn_n = 1'b1;
  endtask
  task automatic t_power_up();
    wait_ctrl(8'hff, 8'h08);
    for (n = 0; n < 3000 && pok !== 1'b1; n++) tick(1);
    for (n = 0; n < 3000 && ctrl[4] !== 1'b1; n++) tick(1);
    chk8({7'h00, n >= 36 && n <= 47}, 8'h01);
    wait_ctrl(8'hff, 8'hfe);
  endtask
  task automatic t_cfg();
    cfg(8'ha2, 1'b0, 8'h00);
    chk8(rd, 8'h00);
    cfg(8'ha2, 1'b1, 8'hff);
    chk8(rd, 8'h08);
    cfg(8'h10, 1'b1, 8'hff);
    chk8(rd, 8'h00);
  endtask
  task automatic t_button();
    press(10);
    tick(40);
    chk8(evts, 8'h00);
    press(30);
    tick(20);
    chk8(evts, 8'h10);
    cfg(8'ha2, 1'b1, 8'h00);
    press(30);
    tick(20);
    chk8(evts, 8'h11);
  endtask
  task automatic t_glitch();
    glitch = 1'b1;
    tick(8);
    glitch = 1'b0;
    wait_ctrl(8'hff, 8'hfe);
  endtask
  task automatic t_sleep(input logic [1:0] ty);
    stype = ty;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    wait_ctrl(8'h04, 8'h00);
    grant = 1'b1;
    tick(1);
    grant = 1'b0;
    wait_ctrl(8'h08, 8'h00);
    tick(150);
    chk8(ctrl & 8'hc0, ty == 2'h0 ? 8'hc0 : (ty == 2'h1 ? 8'h40 : 8'h00));
    if (ty == 2'h1) wake = 1'b1;
    else press(30);
    wait_ctrl(8'hff, 8'hfe);
    wake = 1'b0;
  endtask
  // Reboot bit drops one cycle after the flag, so read back once more
  task automatic t_flags();
    cfg(8'ha2, 1'b0, 8'h00);
    chk8(rd & 8'h11, 8'h11);
    cfg(8'ha2, 1'b1, 8'h01);
    chk8(rd & 8'h01, 8'h00);
    cfg(8'ha2, 1'b0, 8'h00);
    chk8(rd & 8'h11, 8'h00);
  endtask
  task automatic t_override();
    press(260);
    wait_ctrl(8'h40, 8'h00);
    cfg(8'ha2, 1'b0, 8'h00);
    chk8(rd & 8'h04, 8'h04);
    press(30);
    wait_ctrl(8'hff, 8'hfe);
  endtask
  task automatic complete_run();
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #500_000;
    errors++;
    complete_run();
  end
  initial begin
    tick(20);
    rst_n = 1'b1;
    t_power_up();
    t_cfg();
    t_button();
    t_glitch();
    for (int t = 0; t < 3; t++) t_sleep(2'(t));
    t_flags();
    t_override();
    complete_run();
  end
endmodule
`default_nettype wire
